/* File: shared/crf_pkg.sv */
package crf_pkg;

   // ----------------------------------------------------------------
   // register map, word index on the avalon bus (byte address = 4*index)
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_PROG_COUNTER = 4'h0;
   localparam logic [3:0] REG_ACCUMULATOR = 4'h1;
   localparam logic [3:0] REG_INDEX_X = 4'h2;
   localparam logic [3:0] REG_INDEX_Y = 4'h3;
   localparam logic [3:0] REG_STACK_POINTER = 4'h4;
   localparam logic [3:0] REG_STATUS_WORD = 4'h5;
   localparam logic [3:0] REG_RAM_PAGE = 4'h6;
   localparam logic [3:0] REG_CORE_STATE = 4'h7;

   // ----------------------------------------------------------------
   // status word bit positions
   // ----------------------------------------------------------------
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_ZERO = 1;
   localparam int FLAG_IRQ_ENABLE = 2;
   localparam int FLAG_HALF_CARRY = 3;
   localparam int FLAG_BREAK = 4;
   localparam int FLAG_DIRECT_PAGE = 5;
   localparam int FLAG_OVERFLOW = 6;
   localparam int FLAG_NEGATIVE = 7;

   // ----------------------------------------------------------------
   // reset values and fixed program memory locations
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_WORD_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
   localparam logic [15:0] EXT_IRQ0_VECTOR_ADDR = 16'hfffa;
   localparam logic [15:0] TABLE_CALL_BASE = 16'hffc0;
   localparam logic [15:0] PAGE_CALL_BASE = 16'hff00;
   localparam logic [3:0] TABLE_CALL_LAST = 4'hf;
   localparam logic [7:0] STACK_TOP_CUSTOM = 8'hbf;
   localparam logic [7:0] IRQ_SAVE_BYTES = 8'h03;
   localparam logic [7:0] CALL_SAVE_BYTES = 8'h02;

   // ----------------------------------------------------------------
   // core micro-operations
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NONE = 5'h00, OP_STEP = 5'h01, OP_JUMP = 5'h02, OP_ADD = 5'h03,
      OP_SUB = 5'h04, OP_SHIFT_L = 5'h05, OP_SHIFT_R = 5'h06, OP_MOVE = 5'h07,
      OP_BIT_TEST = 5'h08, OP_ENABLE_IRQ = 5'h09, OP_DISABLE_IRQ = 5'h0a,
      OP_CLEAR_OVF = 5'h0b, OP_SET_PAGE = 5'h0c, OP_CLEAR_PAGE = 5'h0d,
      OP_SW_BREAK = 5'h0e, OP_TABLE_CALL = 5'h0f, OP_PAGE_CALL = 5'h10,
      OP_IDX_INC = 5'h11, OP_IDX_DEC = 5'h12, OP_IDX_CMP = 5'h13,
      OP_WORD_LOAD = 5'h14, OP_LOAD_STACK = 5'h15
   } crf_op_t;

   typedef enum logic [1:0] {DST_ACC = 2'h0, DST_X = 2'h1, DST_Y = 2'h2} crf_dst_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'h0, ST_VEC_LO = 2'h1, ST_VEC_HI = 2'h2
   } crf_state_t;

   // one command from the instruction sequencer
   typedef struct packed {
      crf_op_t op;
      crf_dst_t dst;
      logic idx_y;
      logic [7:0] data;
      logic [15:0] word;
      logic [3:0] num;
   } crf_cmd_t;

endpackage : crf_pkg

/* File: design/crf_top.sv */
`timescale 1ns/10ps
`default_nettype none

module crf_top
   import crf_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   // avalon-mm register slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // sequencer command port
   input wire crf_cmd_t cmd_i,
   input wire logic irq_req_i,
   input wire logic [3:0] irq_src_i,
   output logic irq_taken_o,
   output logic busy_o,
   // program memory read port, data in the same cycle as the registered address
   output logic [15:0] pmem_addr_o,
   input wire logic [7:0] pmem_data_i,
   // register views
   output logic [15:0] program_counter_o,
   output logic [15:0] paired_word_register_o,
   output logic [7:0] stack_pointer_o,
   output logic [7:0] program_status_word_o,
   output logic [15:0] eff_addr_o,
   output logic [15:0] direct_addr_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   crf_state_t state_q;
   logic [15:0] program_counter_q;
   logic [7:0] acc_q;
   logic [7:0] idx_x_q;
   logic [7:0] idx_y_q;
   logic [7:0] stack_pointer_q;
   logic [7:0] status_q;
   logic [7:0] ram_page_register_q;
   logic [15:0] vec_q;
   logic [7:0] vec_lo_q;
   logic wait_q;
   logic bus_req;
   logic bus_wr;
   logic [7:0] bus_byte;
   logic run;
   logic irq_go;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // address of table call entry n, highest number at the base
   function automatic logic [15:0] table_vec(input logic [3:0] n);
      logic [3:0] slot;
      slot = TABLE_CALL_LAST - n;
      table_vec = TABLE_CALL_BASE + {11'h000, slot, 1'b0};
   endfunction : table_vec

   // vector of interrupt source n, pairs stepping down from ext 0
   function automatic logic [15:0] irq_vec(input logic [3:0] n);
      irq_vec = EXT_IRQ0_VECTOR_ADDR - {11'h000, n, 1'b0};
   endfunction : irq_vec

   // destination register value for the command
   function automatic logic [7:0] pick(input crf_dst_t d, input logic [7:0] r0,
                                       input logic [7:0] r1, input logic [7:0] r2);
      unique case (d)
         DST_X: pick = r1;
         DST_Y: pick = r2;
         default: pick = r0;
      endcase
   endfunction : pick

   assign bus_req = avs_read_i | avs_write_i;
   assign bus_wr = avs_write_i & ~wait_q;
   assign bus_byte = avs_writedata_i[7:0];
   assign run = (state_q == ST_RUN);
   // maskable requests pass only with the enable flag set
   assign irq_go = run & irq_req_i & status_q[FLAG_IRQ_ENABLE];

   // ----------------------------------------------------------------
   // alu for add, subtract and shifts
   // ----------------------------------------------------------------
   logic [7:0] opnd;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] res;
   logic cout;
   logic ovf;

   assign opnd = pick(cmd_i.dst, acc_q, idx_x_q, idx_y_q);

   always_comb begin
      sum = 9'h000;
      nib = 5'h00;
      res = 8'h00;
      cout = 1'b0;
      ovf = 1'b0;
      unique case (cmd_i.op)
         OP_ADD: begin
            sum = {1'b0, opnd} + {1'b0, cmd_i.data} + {8'h00, status_q[FLAG_CARRY]};
            nib = {1'b0, opnd[3:0]} + {1'b0, cmd_i.data[3:0]} + {4'h0, status_q[FLAG_CARRY]};
            res = sum[7:0];
            cout = sum[8];
            ovf = (opnd[7] == cmd_i.data[7]) && (res[7] != opnd[7]);
         end
         OP_SUB, OP_IDX_CMP: begin
            // carry set means no borrow
            sum = {1'b0, opnd} + {1'b0, ~cmd_i.data} + 9'h001;
            nib = {1'b0, opnd[3:0]} + {1'b0, ~cmd_i.data[3:0]} + 5'h01;
            res = sum[7:0];
            cout = sum[8];
            ovf = (opnd[7] != cmd_i.data[7]) && (res[7] != opnd[7]);
         end
         OP_SHIFT_L: begin
            res = {opnd[6:0], 1'b0};
            cout = opnd[7];
         end
         OP_SHIFT_R: begin
            res = {1'b0, opnd[7:1]};
            cout = opnd[0];
         end
         OP_IDX_INC: res = opnd + 8'h01;
         OP_IDX_DEC: res = opnd - 8'h01;
         default: res = cmd_i.data;
      endcase
   end

   // ----------------------------------------------------------------
   // vector fetch sequencer
   // ----------------------------------------------------------------
   // after reset the first two reads are the reset vector
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_VEC_LO;
         vec_q <= RESET_VECTOR_ADDR;
         vec_lo_q <= DATA_RESET;
      end else begin
         unique case (state_q)
            ST_RUN: begin
               if (irq_go) begin
                  state_q <= ST_VEC_LO;
                  vec_q <= irq_vec(irq_src_i);
               end else if (cmd_i.op == OP_SW_BREAK) begin
                  state_q <= ST_VEC_LO;
                  vec_q <= table_vec(4'h0);
               end else if (cmd_i.op == OP_TABLE_CALL) begin
                  state_q <= ST_VEC_LO;
                  vec_q <= table_vec(cmd_i.num);
               end
            end
            ST_VEC_LO: begin
               state_q <= ST_VEC_HI;
               vec_lo_q <= pmem_data_i;
            end
            ST_VEC_HI: state_q <= ST_RUN;
            default: state_q <= ST_RUN;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // program counter
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         program_counter_q <= RESET_VECTOR_ADDR;
      end else if (state_q == ST_VEC_HI) begin
         program_counter_q <= {pmem_data_i, vec_lo_q};
      end else if (bus_wr && avs_address_i == REG_PROG_COUNTER) begin
         program_counter_q <= avs_writedata_i[15:0];
      end else if (run && !irq_go) begin
         unique case (cmd_i.op)
            OP_STEP: program_counter_q <= program_counter_q + 16'h0001;
            OP_JUMP: program_counter_q <= cmd_i.word;
            OP_PAGE_CALL: program_counter_q <= PAGE_CALL_BASE | {8'h00, cmd_i.data};
            default: program_counter_q <= program_counter_q;
         endcase
      end
   end

   // program memory address follows the counter or the vector
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pmem_addr_o <= RESET_VECTOR_ADDR;
      end else begin
         unique case (state_q)
            ST_RUN: pmem_addr_o <= irq_go ? irq_vec(irq_src_i) :
                                   (cmd_i.op == OP_SW_BREAK) ? table_vec(4'h0) :
                                   (cmd_i.op == OP_TABLE_CALL) ? table_vec(cmd_i.num) :
                                   program_counter_q;
            ST_VEC_LO: pmem_addr_o <= vec_q + 16'h0001;
            ST_VEC_HI: pmem_addr_o <= {pmem_data_i, vec_lo_q};
            default: pmem_addr_o <= program_counter_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // accumulator and index registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_q <= DATA_RESET;
         idx_x_q <= DATA_RESET;
         idx_y_q <= DATA_RESET;
      end else if (bus_wr) begin
         if (avs_address_i == REG_ACCUMULATOR) acc_q <= bus_byte;
         if (avs_address_i == REG_INDEX_X) idx_x_q <= bus_byte;
         if (avs_address_i == REG_INDEX_Y) idx_y_q <= bus_byte;
      end else if (run && !irq_go) begin
         unique case (cmd_i.op)
            OP_WORD_LOAD: begin
               acc_q <= cmd_i.word[7:0];
               idx_y_q <= cmd_i.word[15:8];
            end
            OP_ADD, OP_SUB, OP_SHIFT_L, OP_SHIFT_R, OP_MOVE, OP_IDX_INC, OP_IDX_DEC: begin
               unique case (cmd_i.dst)
                  DST_X: idx_x_q <= res;
                  DST_Y: idx_y_q <= res;
                  default: acc_q <= res;
               endcase
            end
            default: acc_q <= acc_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // stack pointer, deliberately without reset
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (bus_wr && avs_address_i == REG_STACK_POINTER) begin
         stack_pointer_q <= bus_byte;
      end else if (irq_go) begin
         stack_pointer_q <= stack_pointer_q - IRQ_SAVE_BYTES;
      end else if (run) begin
         unique case (cmd_i.op)
            OP_LOAD_STACK: stack_pointer_q <= cmd_i.data;
            OP_SW_BREAK: stack_pointer_q <= stack_pointer_q - IRQ_SAVE_BYTES;
            OP_TABLE_CALL, OP_PAGE_CALL: stack_pointer_q <= stack_pointer_q - CALL_SAVE_BYTES;
            default: stack_pointer_q <= stack_pointer_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // status word flags
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_q <= STATUS_WORD_RESET;
      end else if (irq_go) begin
         status_q[FLAG_IRQ_ENABLE] <= 1'b0;
      end else if (run) begin
         if (bus_wr && avs_address_i == REG_STATUS_WORD) status_q <= bus_byte;
         unique case (cmd_i.op)
            OP_ADD, OP_SUB: begin
               status_q[FLAG_CARRY] <= cout;
               status_q[FLAG_OVERFLOW] <= status_q[FLAG_OVERFLOW] | ovf;
               status_q[FLAG_HALF_CARRY] <= status_q[FLAG_HALF_CARRY] | nib[4];
               status_q[FLAG_ZERO] <= (res == 8'h00);
               status_q[FLAG_NEGATIVE] <= res[7];
            end
            OP_SHIFT_L, OP_SHIFT_R, OP_IDX_CMP: begin
               status_q[FLAG_CARRY] <= cout;
               status_q[FLAG_ZERO] <= (res == 8'h00);
               status_q[FLAG_NEGATIVE] <= res[7];
            end
            OP_MOVE, OP_IDX_INC, OP_IDX_DEC: begin
               status_q[FLAG_ZERO] <= (res == 8'h00);
               status_q[FLAG_NEGATIVE] <= res[7];
            end
            OP_BIT_TEST: begin
               status_q[FLAG_OVERFLOW] <= cmd_i.data[6];
               status_q[FLAG_NEGATIVE] <= cmd_i.data[7];
            end
            OP_ENABLE_IRQ: status_q[FLAG_IRQ_ENABLE] <= 1'b1;
            OP_DISABLE_IRQ: status_q[FLAG_IRQ_ENABLE] <= 1'b0;
            OP_CLEAR_OVF: begin
               status_q[FLAG_OVERFLOW] <= 1'b0;
               status_q[FLAG_HALF_CARRY] <= 1'b0;
            end
            OP_SET_PAGE: status_q[FLAG_DIRECT_PAGE] <= 1'b1;
            OP_CLEAR_PAGE: status_q[FLAG_DIRECT_PAGE] <= 1'b0;
            OP_SW_BREAK: status_q[FLAG_BREAK] <= 1'b1;
            // no flag update, so a status write in this cycle keeps every bit
            default: ;
         endcase
      end else if (bus_wr && avs_address_i == REG_STATUS_WORD) begin
         status_q <= bus_byte;
      end
   end

   // ram page register
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ram_page_register_q <= DATA_RESET;
      end else if (bus_wr && avs_address_i == REG_RAM_PAGE) begin
         ram_page_register_q <= bus_byte;
      end
   end

   // ----------------------------------------------------------------
   // address generation and register views
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         eff_addr_o <= 16'h0000;
         direct_addr_o <= 16'h0000;
         irq_taken_o <= 1'b0;
         busy_o <= 1'b1;
      end else begin
         eff_addr_o <= cmd_i.word + {8'h00, cmd_i.idx_y ? idx_y_q : idx_x_q};
         direct_addr_o <= {status_q[FLAG_DIRECT_PAGE] ? ram_page_register_q : 8'h00,
                           cmd_i.data};
         irq_taken_o <= irq_go;
         busy_o <= (state_q == ST_VEC_LO) || irq_go ||
                   (run && (cmd_i.op == OP_SW_BREAK || cmd_i.op == OP_TABLE_CALL));
      end
   end

   always_ff @(posedge clock_i) begin
      stack_pointer_o <= stack_pointer_q;
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         program_counter_o <= RESET_VECTOR_ADDR;
         paired_word_register_o <= 16'h0000;
         program_status_word_o <= STATUS_WORD_RESET;
      end else begin
         program_counter_o <= program_counter_q;
         paired_word_register_o <= {idx_y_q, acc_q};
         program_status_word_o <= status_q;
      end
   end

   // ----------------------------------------------------------------
   // avalon slave: one wait cycle, then the answer
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_q <= 1'b1;
         avs_readdata_o <= 32'h0000_0000;
      end else if (bus_req && wait_q) begin
         wait_q <= 1'b0;
         unique case (avs_address_i)
            REG_PROG_COUNTER: avs_readdata_o <= {16'h0000, program_counter_q};
            REG_ACCUMULATOR: avs_readdata_o <= {24'h000000, acc_q};
            REG_INDEX_X: avs_readdata_o <= {24'h000000, idx_x_q};
            REG_INDEX_Y: avs_readdata_o <= {24'h000000, idx_y_q};
            REG_STACK_POINTER: avs_readdata_o <= {24'h000000, stack_pointer_q};
            REG_STATUS_WORD: avs_readdata_o <= {24'h000000, status_q};
            REG_RAM_PAGE: avs_readdata_o <= {24'h000000, ram_page_register_q};
            REG_CORE_STATE: avs_readdata_o <= {30'h0000_0000, state_q};
            default: avs_readdata_o <= 32'h0000_0000;
         endcase
      end else begin
         wait_q <= 1'b1;
      end
   end

   assign avs_waitrequest_o = wait_q;

endmodule : crf_top

`default_nettype wire

/* File: dv/crf_top_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// checker on the top-level ports
// ----------------------------------------
module crf_top_assertions
   import crf_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire crf_cmd_t cmd_i,
   input wire logic irq_req_i,
   input wire logic [3:0] irq_src_i,
   input wire logic irq_taken_o,
   input wire logic busy_o,
   input wire logic [15:0] pmem_addr_o,
   input wire logic [7:0] program_status_word_o,
   input wire logic [15:0] direct_addr_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // bus answers after exactly one wait cycle and holds low for one
   bus_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer timing off");
   unmapped_zero_a: assert property (avs_read_i && avs_address_i[3] && avs_waitrequest_o
      |=> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
   // reset vector fetch starts at the top of program memory
   reset_fetch_a: assert property ($rose(rst_n_i) |-> pmem_addr_o == RESET_VECTOR_ADDR && busy_o
      ##1 pmem_addr_o == 16'hffff) else $error("reset vector fetch wrong");
   irq_gate_a: assert property (irq_taken_o |-> $past(irq_req_i)
      ##1 !program_status_word_o[FLAG_IRQ_ENABLE]) else $error("interrupt gate wrong");
   irq_vector_a: assert property (irq_taken_o |-> pmem_addr_o == EXT_IRQ0_VECTOR_ADDR
      - {11'h0, $past(irq_src_i), 1'b0} ##1 !irq_taken_o) else $error("irq vector wrong");
   table_addr_a: assert property (cmd_i.op == OP_TABLE_CALL && !busy_o && !$past(busy_o)
      && !irq_req_i |=> pmem_addr_o == TABLE_CALL_BASE + {11'h0, ~$past(cmd_i.num), 1'b0})
      else $error("table call entry wrong");
   page_zero_a: assert property (!program_status_word_o[FLAG_DIRECT_PAGE]
      |-> direct_addr_o[15:8] == 8'h00) else $error("direct page not zero");
   half_sticky_a: assert property ($fell(program_status_word_o[FLAG_HALF_CARRY])
      |-> $past(cmd_i.op, 2) == OP_CLEAR_OVF || $past(avs_write_i, 2))
      else $error("half carry cleared wrongly");
endmodule : crf_top_assertions

bind crf_top crf_top_assertions crf_top_assertions_inst (.clock_i, .rst_n_i, .avs_address_i,
   .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .cmd_i, .irq_req_i,
   .irq_src_i, .irq_taken_o, .busy_o, .pmem_addr_o, .program_status_word_o, .direct_addr_o);
`default_nettype wire

/* File: dv/crf_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module crf_top_bench;
   import crf_pkg::*;
   typedef struct packed {
      crf_cmd_t cmd;
      logic [7:0] mask;
      logic [7:0] program_status_word;
      logic [7:0] acc;
      logic acck;
   } crf_row_t;
   logic clock_i, rst_n_i, avs_read_i, avs_write_i, irq_req_i, avs_waitrequest_o;
   logic irq_taken_o, busy_o;
   logic [3:0] avs_address_i, irq_src_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   crf_cmd_t cmd_i;
   logic [7:0] pmem_data_i, stack_pointer_o, program_status_word_o, sp_e;
   logic [15:0] pmem_addr_o, program_counter_o, paired_word_register_o, eff_addr_o;
   logic [15:0] direct_addr_o;
   crf_row_t rows[12];
   int n_fail = 0;
   int samples_checked = 0;

   crf_top crf_top_inst (.clock_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .cmd_i, .irq_req_i, .irq_src_i,
      .irq_taken_o, .busy_o, .pmem_addr_o, .pmem_data_i, .program_counter_o,
      .paired_word_register_o, .stack_pointer_o, .program_status_word_o, .eff_addr_o,
      .direct_addr_o);

   // ----------------------------------------
   // clock, program memory, helpers
   // ----------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // program memory reads the registered address within the same cycle
   assign pmem_data_i = pm(pmem_addr_o);
   function automatic logic [7:0] pm(input logic [15:0] a);
      pm = a[7:0] ^ 8'h3c;
   endfunction : pm
   function automatic logic [15:0] vec(input logic [15:0] a);
      vec = {pm(a + 16'h1), pm(a)};
   endfunction : vec
   function automatic crf_cmd_t mk(input crf_op_t op, input crf_dst_t d, input logic [7:0] v,
      input logic [15:0] w, input logic [3:0] n);
      mk = '{op: op, dst: d, idx_y: 1'b0, data: v, word: w, num: n};
   endfunction : mk
   function automatic crf_row_t r(input crf_op_t op, input logic [7:0] v, input logic [7:0] m,
      input logic [7:0] p, input logic [7:0] a, input logic k);
      r = '{cmd: mk(op, DST_ACC, v, 16'h0, 4'h0), mask: m, program_status_word: p, acc: a, acck: k};
   endfunction : r
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   // avalon master: hold until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int k;
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      k = 0;
      do begin
         @(posedge clock_i);
         k++;
      end while (avs_waitrequest_o !== 1'b0 && k < 50);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : bus
   // one command for one cycle, then wait until the views show it
   task automatic issue(input crf_cmd_t c);
      @(posedge clock_i);
      cmd_i <= c;
      @(posedge clock_i);
      cmd_i <= '0;
      repeat (2) @(posedge clock_i);
   endtask : issue
   task automatic wait_idle();
      int k;
      k = 0;
      while (busy_o !== 1'b0 && k < 40) begin
         @(posedge clock_i);
         k++;
      end
      repeat (2) @(posedge clock_i);
   endtask : wait_idle
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   // ----------------------------------------
   // watchdog and main sequence
   // ----------------------------------------
   initial begin
      #200us;
      n_fail++;
      $display("wrong value at %0t: run did not finish", $time);
      stop_test();
   end
   initial begin
      {rst_n_i, avs_read_i, avs_write_i, irq_req_i, irq_src_i, avs_address_i} = '0;
      avs_writedata_i = '0;
      cmd_i = '0;
      rows = '{r(OP_MOVE, 8'h00, 8'h82, 8'h02, 8'h00, 1), r(OP_MOVE, 8'h7f, 8'h82, 8'h00, 8'h7f, 1),
         r(OP_ADD, 8'h01, 8'hcb, 8'hc8, 8'h80, 1), r(OP_CLEAR_OVF, 8'h00, 8'h48, 8'h00, 8'h80, 1),
         r(OP_ADD, 8'h80, 8'hcb, 8'h43, 8'h00, 1), r(OP_SHIFT_L, 8'h00, 8'h01, 8'h00, 8'h00, 0),
         r(OP_BIT_TEST, 8'hc0, 8'hc0, 8'hc0, 8'h00, 0), r(OP_CLEAR_OVF, 8'h0, 8'h48, 8'h0, 8'h0, 0),
         r(OP_ENABLE_IRQ, 8'h0, 8'h04, 8'h04, 8'h0, 0), r(OP_DISABLE_IRQ, 8'h0, 8'h04, 8'h0, 8'h0, 0),
         r(OP_SET_PAGE, 8'h00, 8'h20, 8'h20, 8'h00, 0), r(OP_CLEAR_PAGE, 8'h0, 8'h20, 8'h0, 8'h0, 0)};
      repeat (12) @(posedge clock_i);
      chk(pmem_addr_o, RESET_VECTOR_ADDR, "reset address");
      chk(program_status_word_o, STATUS_WORD_RESET, "reset status");
      rst_n_i <= 1'b1;
      wait_idle();
      chk(program_counter_o, vec(RESET_VECTOR_ADDR), "start address");
      $display("reset test done");
      sp_e = STACK_TOP_CUSTOM;
      bus(1'b1, REG_STACK_POINTER, {24'h0, sp_e}, rd);
      bus(1'b0, REG_STACK_POINTER, 32'h0, rd);
      chk(rd[15:0], {8'h00, sp_e}, "stack pointer read");
      bus(1'b0, 4'h9, 32'h0, rd);
      chk(rd[15:0], 16'h0, "unmapped read");
      $display("register bus test done");
      foreach (rows[i]) begin
         issue(rows[i].cmd);
         chk(program_status_word_o & rows[i].mask, rows[i].program_status_word, "flags");
         if (rows[i].acck) chk(paired_word_register_o[7:0], rows[i].acc, "accumulator");
      end
      $display("flag table done");
      issue(mk(OP_MOVE, DST_Y, 8'h12, 16'h0, 4'h0));
      chk(paired_word_register_o[15:8], 16'h12, "paired upper byte");
      issue(mk(OP_MOVE, DST_X, 8'h05, 16'h0, 4'h0));
      @(posedge clock_i);
      cmd_i <= mk(OP_NONE, DST_ACC, 8'h21, 16'h1000, 4'h0);
      repeat (3) @(posedge clock_i);
      chk(eff_addr_o, 16'h1005, "indexed address");
      chk(direct_addr_o, 16'h0021, "direct address");
      issue(mk(OP_JUMP, DST_ACC, 8'h00, 16'hffff, 4'h0));
      issue(mk(OP_STEP, DST_ACC, 8'h00, 16'h0, 4'h0));
      chk(program_counter_o, 16'h0000, "counter wrap");
      $display("index and wrap test done");
      issue(mk(OP_PAGE_CALL, DST_ACC, 8'h40, 16'h0, 4'h0));
      wait_idle();
      sp_e = sp_e - CALL_SAVE_BYTES;
      chk(program_counter_o, PAGE_CALL_BASE | 16'h0040, "page call");
      issue(mk(OP_TABLE_CALL, DST_ACC, 8'h00, 16'h0, 4'h3));
      wait_idle();
      sp_e = sp_e - CALL_SAVE_BYTES;
      chk(program_counter_o, vec(TABLE_CALL_BASE + 16'd24), "table call");
      chk(stack_pointer_o, sp_e, "stack after calls");
      issue(mk(OP_SW_BREAK, DST_ACC, 8'h00, 16'h0, 4'h0));
      wait_idle();
      sp_e = sp_e - IRQ_SAVE_BYTES;
      chk(program_counter_o, vec(16'hffde), "break vector");
      chk(program_status_word_o[FLAG_BREAK], 1'b1, "break flag");
      $display("call test done");
      irq_src_i <= 4'h1;
      irq_req_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      chk(busy_o, 1'b0, "masked interrupt");
      issue(mk(OP_ENABLE_IRQ, DST_ACC, 8'h00, 16'h0, 4'h0));
      wait_idle();
      irq_req_i <= 1'b0;
      sp_e = sp_e - IRQ_SAVE_BYTES;
      chk(program_counter_o, vec(16'hfff8), "interrupt vector");
      chk(program_status_word_o[FLAG_IRQ_ENABLE], 1'b0, "enable after service");
      chk(stack_pointer_o, sp_e, "stack after interrupt");
      $display("interrupt test done");
      stop_test();
   end
endmodule : crf_top_bench
`default_nettype wire
